/* File: core/first_port_pins_pkg.sv */
// Package: register map, field positions and carriers for the eight-bit port
package first_port_pins_pkg;

   // ----------------------------------------
   // Register map (word indices)
   // ----------------------------------------
   localparam logic [7:0] PINS_IDX = 8'h05;
   localparam logic [7:0] DIR_IDX = 8'h85;
   localparam logic [7:0] CMP_CTRL_IDX = 8'h1f;
   localparam logic [7:0] VREF_CTRL_IDX = 8'h9f;
   localparam logic [7:0] CFG_IDX = 8'hc0;
   localparam int ADDR_W = 10;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] DIR_RESET = 8'hff;
   localparam logic [7:0] CMP_CTRL_RESET = 8'h00;
   localparam logic [7:0] VREF_CTRL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CMP_MODE_LSB = 0;
   localparam int CMP_MODE_W = 3;
   localparam int VREF_OE_BIT = 6;
   localparam int VREF_EN_BIT = 7;
   localparam int CFG_CLEAR_BIT = 0;
   localparam int CFG_OSC_LSB = 1;
   localparam int CFG_OSC_W = 2;
   localparam int PIN_REF = 2;
   localparam int PIN_CMP_OUT1 = 3;
   localparam int PIN_OD = 4;
   localparam int PIN_IN_ONLY = 5;
   localparam int PIN_OSC_OUT = 6;
   localparam int PIN_OSC_IN = 7;

   // ----------------------------------------
   // Comparator modes
   // ----------------------------------------
   localparam logic [2:0] CMP_RESET_MODE = 3'h0;
   localparam logic [2:0] CMP_OUTPUT_MODE = 3'h6;
   localparam logic [2:0] CMP_OFF_MODE = 3'h7;

   typedef enum logic [1:0] {OSC_XTAL, OSC_EXT_CLK, OSC_RC_QUARTER, OSC_INT_IO} osc_mode_e;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [ADDR_W-1:0] adr;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } pin_drive_s;

endpackage

/* File: core/first_port_pins_sync.sv */
// Two-flop synchroniser for the pin and side inputs
`timescale 1ns/1ps
module first_port_pins_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

/* File: core/first_port_pins_port.sv */
// Eight-bit port with shared comparator, timer, clear and oscillator pins and a reference output enable
//
// Contract
// - Eight latch bits, eight direction bits
// - Pin four: Schmitt input, open-drain output
// - Pin five input-only, never driven
// - Direction one floats pin, zero drives latch
// - Reads return pins; writes update latch
// - Writes merge new bytes over sampled pins
// - Comparator input pins read as zero
// - Reset: all inputs, pins 0-3 digital off
// - Oscillator-claimed pins six, seven read zero
// - Comparator outputs drive only with direction cleared
// - Pin use chosen by comparator, oscillator controls
// - Pin four feeds timer external clock
// - Fuse picks pin five: input or clear
// - Pin six outputs quarter clock in RC quarter mode only
// - Enabled comparator outputs and oscillator take pins from port; reference output leaves pin two to the port
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module first_port_pins_port (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [3:0] SEL_I,
   input wire logic [first_port_pins_pkg::ADDR_W-1:0] ADR_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // Port pins
   input wire logic [7:0] PIN_I,
   output logic [7:0] PIN_O,
   output logic [7:0] PIN_OE,
   // Peripheral hookups
   input wire logic COMPARATOR_ONE_OUT,
   input wire logic COMPARATOR_TWO_OUT,
   input wire logic QUARTER_CLOCK_IN,
   input wire logic MASTER_CLEAR_SELECT_FUSE,
   output logic TIMER_EXT_CLOCK_IN,
   output logic MASTER_CLEAR_IN_N,
   output logic COMPARATOR_INPUTS_GROUNDED,
   output logic VREF_OUT_EN,
   output logic [2:0] CMP_MODE,
   output logic [1:0] OSC_MODE
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   first_port_pins_pkg::wb_req_s req;
   logic [7:0] latch_q;
   logic [7:0] dir_q;
   logic [7:0] cmp_ctrl_q;
   logic [7:0] vref_ctrl_q;
   logic [7:0] cfg_q;
   logic [7:0] pins_sync;
   logic [1:0] side_sync;
   logic ack_q;
   logic [31:0] dat_q;
   logic [7:0] pin_read;
   logic [7:0] dir_read;
   logic [7:0] cmp_in_mask;
   logic osc_claims_pins;
   logic quarter_out_on;
   logic cmp_outputs_on;
   logic clear_pin_on;
   logic [2:0] cmp_mode;
   first_port_pins_pkg::osc_mode_e osc_mode;
   first_port_pins_pkg::pin_drive_s drv;
   logic access;
   logic wr;

   // Merge selected low byte over a base byte
   function automatic logic [7:0] merge_byte(input logic [7:0] base, input logic [31:0] wdat,
      input logic [3:0] sel);
      merge_byte = sel[0] ? wdat[7:0] : base;
   endfunction

   // Comparator inputs claimed by each mode
   function automatic logic [7:0] cmp_inputs(input logic [2:0] mode);
      case (mode)
         first_port_pins_pkg::CMP_OFF_MODE: cmp_inputs = 8'h00;
         first_port_pins_pkg::CMP_OUTPUT_MODE: cmp_inputs = 8'h07;
         default: cmp_inputs = 8'h0f;
      endcase
   endfunction

   assign req = '{cyc: CYC_I, stb: STB_I, we: WE_I, sel: SEL_I, adr: ADR_I, dat: DAT_I};
   assign access = req.cyc && req.stb && !ack_q;
   assign wr = access && req.we;

   // ----------------------------------------
   // Pin and side input synchronisers
   // ----------------------------------------
   first_port_pins_sync #(.W(8)) u_pin_sync (
      .clk(CLK),
      .rst(RST),
      .d(PIN_I),
      .q(pins_sync)
   );

   first_port_pins_sync #(.W(2)) u_side_sync (
      .clk(CLK),
      .rst(RST),
      .d({QUARTER_CLOCK_IN, MASTER_CLEAR_SELECT_FUSE}),
      .q(side_sync)
   );

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   assign cmp_mode = cmp_ctrl_q[first_port_pins_pkg::CMP_MODE_LSB +: first_port_pins_pkg::CMP_MODE_W];
   assign osc_mode = first_port_pins_pkg::osc_mode_e'(cfg_q[first_port_pins_pkg::CFG_OSC_LSB +: first_port_pins_pkg::CFG_OSC_W]);
   assign cmp_in_mask = cmp_inputs(cmp_mode);
   assign cmp_outputs_on = (cmp_mode == first_port_pins_pkg::CMP_OUTPUT_MODE);
   assign osc_claims_pins = (osc_mode != first_port_pins_pkg::OSC_INT_IO);
   assign quarter_out_on = (osc_mode == first_port_pins_pkg::OSC_RC_QUARTER);
   assign clear_pin_on = side_sync[0];

   // ----------------------------------------
   // Read values
   // ----------------------------------------
   always_comb
   begin
      pin_read = pins_sync & ~cmp_in_mask;
      if (osc_claims_pins)
      begin
         pin_read[first_port_pins_pkg::PIN_OSC_OUT] = 1'b0;
         pin_read[first_port_pins_pkg::PIN_OSC_IN] = 1'b0;
      end
      if (clear_pin_on)
      begin
         pin_read[first_port_pins_pkg::PIN_IN_ONLY] = 1'b0;
      end
      dir_read = dir_q;
      dir_read[first_port_pins_pkg::PIN_IN_ONLY] = 1'b1;
   end

   // ----------------------------------------
   // Output latch
   // ----------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         latch_q <= 8'h00;
      end
      else if (wr && req.adr == {2'b00, first_port_pins_pkg::PINS_IDX})
      begin
         latch_q <= merge_byte(pin_read, req.dat, req.sel);
      end
   end

   // ----------------------------------------
   // Direction register
   // ----------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         dir_q <= first_port_pins_pkg::DIR_RESET;
      end
      else if (wr && req.adr == {2'b00, first_port_pins_pkg::DIR_IDX})
      begin
         dir_q <= merge_byte(dir_q, req.dat, req.sel);
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         cmp_ctrl_q <= first_port_pins_pkg::CMP_CTRL_RESET;
         vref_ctrl_q <= first_port_pins_pkg::VREF_CTRL_RESET;
         cfg_q <= first_port_pins_pkg::CFG_RESET;
      end
      else if (wr)
      begin
         if (req.adr == {2'b00, first_port_pins_pkg::CMP_CTRL_IDX})
         begin
            cmp_ctrl_q <= merge_byte(cmp_ctrl_q, req.dat, req.sel);
         end
         if (req.adr == {2'b00, first_port_pins_pkg::VREF_CTRL_IDX})
         begin
            vref_ctrl_q <= merge_byte(vref_ctrl_q, req.dat, req.sel) & 8'hef;
         end
         if (req.adr == {2'b00, first_port_pins_pkg::CFG_IDX})
         begin
            cfg_q <= merge_byte(cfg_q, req.dat, req.sel) & 8'h06;
         end
      end
   end

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= access;
         if (access && !req.we)
         begin
            unique case (req.adr)
               {2'b00, first_port_pins_pkg::PINS_IDX}: dat_q <= {24'h00_0000, pin_read};
               {2'b00, first_port_pins_pkg::DIR_IDX}: dat_q <= {24'h00_0000, dir_read};
               {2'b00, first_port_pins_pkg::CMP_CTRL_IDX}: dat_q <= {24'h00_0000, cmp_ctrl_q};
               {2'b00, first_port_pins_pkg::VREF_CTRL_IDX}: dat_q <= {24'h00_0000, vref_ctrl_q};
               {2'b00, first_port_pins_pkg::CFG_IDX}: dat_q <= {24'h00_0000, cfg_q[7:1], clear_pin_on};
               default: dat_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign ACK_O = ack_q;
   assign DAT_O = dat_q;

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   always_comb
   begin
      drv.o = latch_q;
      drv.oe = ~dir_q;
      // Open drain: only a low is driven
      drv.o[first_port_pins_pkg::PIN_OD] = 1'b0;
      drv.oe[first_port_pins_pkg::PIN_OD] = ~dir_q[first_port_pins_pkg::PIN_OD] & ~latch_q[first_port_pins_pkg::PIN_OD];
      if (cmp_outputs_on)
      begin
         drv.o[first_port_pins_pkg::PIN_CMP_OUT1] = COMPARATOR_ONE_OUT;
         drv.oe[first_port_pins_pkg::PIN_OD] = ~dir_q[first_port_pins_pkg::PIN_OD] & ~COMPARATOR_TWO_OUT;
      end
      drv.oe[first_port_pins_pkg::PIN_IN_ONLY] = 1'b0;
      drv.o[first_port_pins_pkg::PIN_IN_ONLY] = 1'b0;
      if (osc_claims_pins)
      begin
         drv.oe[first_port_pins_pkg::PIN_OSC_OUT] = quarter_out_on;
         drv.o[first_port_pins_pkg::PIN_OSC_OUT] = quarter_out_on & side_sync[1];
         drv.oe[first_port_pins_pkg::PIN_OSC_IN] = 1'b0;
         drv.o[first_port_pins_pkg::PIN_OSC_IN] = 1'b0;
      end
   end

   assign PIN_O = drv.o;
   assign PIN_OE = drv.oe;

   // ----------------------------------------
   // Peripheral taps
   // ----------------------------------------
   assign TIMER_EXT_CLOCK_IN = pins_sync[first_port_pins_pkg::PIN_OD];
   assign MASTER_CLEAR_IN_N = clear_pin_on ? pins_sync[first_port_pins_pkg::PIN_IN_ONLY] : 1'b1;
   assign COMPARATOR_INPUTS_GROUNDED = (cmp_mode == first_port_pins_pkg::CMP_RESET_MODE);
   assign VREF_OUT_EN = vref_ctrl_q[first_port_pins_pkg::VREF_EN_BIT] & vref_ctrl_q[first_port_pins_pkg::VREF_OE_BIT];
   assign CMP_MODE = cmp_mode;
   assign OSC_MODE = cfg_q[first_port_pins_pkg::CFG_OSC_LSB +: first_port_pins_pkg::CFG_OSC_W];

endmodule

/* File: verif/first_port_pins_port_sva.sv */
// Checker for the eight-bit port
`timescale 1ns/1ps
module first_port_pins_port_sva (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Bus
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic ACK_O,
   // Pins and hookups
   input wire logic [7:0] PIN_I,
   input wire logic [7:0] PIN_O,
   input wire logic [7:0] PIN_OE,
   input wire logic COMPARATOR_ONE_OUT,
   input wire logic COMPARATOR_TWO_OUT,
   input wire logic QUARTER_CLOCK_IN,
   input wire logic TIMER_EXT_CLOCK_IN,
   input wire logic [2:0] CMP_MODE,
   input wire logic [1:0] OSC_MODE
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   ack_resp_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("no ack");
   pin5_float_a: assert property (!PIN_OE[5])
      else $error("pin five driven");
   od_low_a: assert property (PIN_OE[4] |-> !PIN_O[4])
      else $error("pin four driven high");
   dir_reset_a: assert property ($fell(RST) |-> PIN_OE == 8'h00)
      else $error("pins driven after reset");
   timer_in_a: assert property (!$past(RST) && !$past(RST, 2) |-> TIMER_EXT_CLOCK_IN == $past(PIN_I[4], 2))
      else $error("timer clock wrong");
   cmp_out_a: assert property (CMP_MODE == 3'h6 && PIN_OE[3] |-> PIN_O[3] == COMPARATOR_ONE_OUT)
      else $error("comparator output wrong");
   osc_claim_a: assert property (OSC_MODE != 2'h3 |-> !PIN_OE[7])
      else $error("pin seven driven");
   quarter_out_a: assert property (!$past(RST) && !$past(RST, 2) && OSC_MODE == 2'h2
      |-> PIN_OE[6] && PIN_O[6] == $past(QUARTER_CLOCK_IN, 2))
      else $error("quarter clock wrong");
   comparator_two_out_drive_a: assert property (CMP_MODE == 3'h6 && COMPARATOR_TWO_OUT |-> !PIN_OE[4])
      else $error("comparator two drives pin four");
   ack_pulse_a: assert property (ACK_O |=> !ACK_O)
      else $error("ack held too long");
endmodule
bind first_port_pins_port first_port_pins_port_sva i_sva (.CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
   .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .COMPARATOR_ONE_OUT(COMPARATOR_ONE_OUT),
   .COMPARATOR_TWO_OUT(COMPARATOR_TWO_OUT), .QUARTER_CLOCK_IN(QUARTER_CLOCK_IN),
   .TIMER_EXT_CLOCK_IN(TIMER_EXT_CLOCK_IN), .CMP_MODE(CMP_MODE), .OSC_MODE(OSC_MODE));

/* File: verif/pin_load.sv */
// External circuitry on the port pins
`timescale 1ns/1ps
module pin_load (
   // Port side
   input wire logic [7:0] o,
   input wire logic [7:0] oe,
   // Undriven levels in, resolved pin levels out
   input wire logic [7:0] ext,
   output logic [7:0] lvl
);
   assign lvl = (oe & o) | (~oe & ext);
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the eight-bit port
`timescale 1ns/1ps
module tb_top;
   logic CLK = 0, RST = 1, cyc = 0, stb = 0, we = 0;
   logic c1 = 0, c2 = 0, qc = 0, fz = 0, s;
   logic ack, tck, mcn, gnd, vre;
   logic [3:0] sel = 4'h0;
   logic [9:0] adr = 10'h0;
   logic [31:0] dat = 32'h0, rdat, got;
   logic [7:0] ext = 8'h0, lat = 8'h0, dir = 8'hff;
   logic [7:0] po, poe, lvl, oe, o, lv, rd, d;
   logic [2:0] cm = 3'h0, cmo;
   logic [1:0] osc = 2'h0, osco;
   int miscompares = 0, total_checks = 0, cycles = 0, seed = 32'hfb67;
   first_port_pins_port i_dut (.CLK(CLK), .RST(RST), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .SEL_I(sel), .ADR_I(adr),
      .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack), .PIN_I(lvl), .PIN_O(po), .PIN_OE(poe), .COMPARATOR_ONE_OUT(c1),
      .COMPARATOR_TWO_OUT(c2), .QUARTER_CLOCK_IN(qc), .MASTER_CLEAR_SELECT_FUSE(fz), .TIMER_EXT_CLOCK_IN(tck),
      .MASTER_CLEAR_IN_N(mcn), .COMPARATOR_INPUTS_GROUNDED(gnd), .VREF_OUT_EN(vre), .CMP_MODE(cmo),
      .OSC_MODE(osco));
   pin_load i_load (.o(po), .oe(poe), .ext(ext), .lvl(lvl));
   always #4 CLK = ~CLK;
   always @(posedge CLK)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         miscompares++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   // One classic cycle, read data left in got
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] v, input logic b);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'b00, a};
      dat <= {24'h0, v};
      sel <= {3'h0, b};
      do
         @(posedge CLK);
      while (ack !== 1'b1);
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge CLK);
   endtask
   // Expected drive, pin levels and read value
   task automatic model();
      oe = ~dir;
      oe[5] = 1'b0;
      oe[4] = ~dir[4] & ~((cm == 3'h6) ? c2 : lat[4]);
      o = lat;
      o[4] = 1'b0;
      if (cm == 3'h6)
         o[3] = c1;
      if (osc != 2'h3)
         oe[7:6] = {1'b0, osc == 2'h2};
      if (osc == 2'h2)
         o[6] = qc;
      lv = (oe & o) | (~oe & ext);
      rd = lv & ~((cm == 3'h7) ? 8'h00 : (cm == 3'h6) ? 8'h07 : 8'h0f);
      if (osc != 2'h3)
         rd[7:6] = 2'b00;
      if (fz)
         rd[5] = 1'b0;
   endtask
   initial
   begin
      ext = 8'($random(seed));
      repeat (4) @(posedge CLK);
      RST <= 1'b0;
      wb(first_port_pins_pkg::DIR_IDX, 1'b0, 8'h00, 1'b1);
      chk(got, 32'hff);
      model();
      wb(first_port_pins_pkg::PINS_IDX, 1'b0, 8'h00, 1'b1);
      chk(got, 32'(rd));
      $display("test reset done");
      for (int k = 0; k < 16; k++)
      begin
         cm = (k < 4) ? 3'h7 : 3'(k);
         osc = 2'(k) + 2'(k >> 2);
         dir = 8'($random(seed));
         if (cm == 3'h6)
            dir[2:0] = 3'h7;
         else if (cm != 3'h7)
            dir[3:0] = 4'hf;
         ext <= 8'($random(seed));
         {c1, c2, qc, fz} <= 4'($random(seed));
         wb(first_port_pins_pkg::CMP_CTRL_IDX, 1'b1, {5'h0, cm}, 1'b1);
         wb(first_port_pins_pkg::CFG_IDX, 1'b1, {5'h0, osc, 1'b0}, 1'b1);
         wb(first_port_pins_pkg::DIR_IDX, 1'b1, dir, 1'b1);
         repeat (3) @(posedge CLK);
         model();
         d = 8'($random(seed));
         s = k[0] ^ k[2];
         lat = s ? d : rd;
         wb(first_port_pins_pkg::PINS_IDX, 1'b1, d, s);
         repeat (3) @(posedge CLK);
         model();
         chk(32'(poe), 32'(oe));
         chk(32'(po & oe), 32'(o & oe));
         chk(32'({tck, mcn, cmo, osco, gnd}), 32'({lv[4], ~fz | lv[5], cm, osc, cm == 3'h0}));
         wb(first_port_pins_pkg::PINS_IDX, 1'b0, 8'h00, 1'b1);
         chk(got, 32'(rd));
         wb(first_port_pins_pkg::DIR_IDX, 1'b0, 8'h00, 1'b1);
         chk(got, 32'(dir | 8'h20));
         wb(first_port_pins_pkg::CFG_IDX, 1'b0, 8'h00, 1'b1);
         chk(got, 32'({osc, fz}));
      end
      $display("test pins done");
      wb(first_port_pins_pkg::DIR_IDX, 1'b1, dir | 8'h04, 1'b1);
      wb(first_port_pins_pkg::VREF_CTRL_IDX, 1'b1, 8'hff, 1'b1);
      wb(first_port_pins_pkg::VREF_CTRL_IDX, 1'b0, 8'h00, 1'b1);
      chk(got, 32'hef);
      chk(32'(vre), 32'h1);
      wb(8'h03, 1'b1, 8'h5a, 1'b1);
      wb(8'h03, 1'b0, 8'h00, 1'b1);
      chk(got, 32'h0);
      RST <= 1'b1;
      @(posedge CLK);
      RST <= 1'b0;
      wb(first_port_pins_pkg::DIR_IDX, 1'b0, 8'h00, 1'b1);
      chk(got, 32'hff);
      chk(32'({gnd, vre}), 32'h2);
      $display("test regs done");
      test_done();
   end
endmodule
